// [src/sdram_cfg_pkg.sv]
// constants, encodings and state codes of the sdram control block
package sdram_cfg_pkg;

  // ********************************************************
  // register byte offsets
  // ********************************************************
  localparam logic [7:0] MODE_REG_OFS = 8'h00;
  localparam logic [7:0] REFR_REG_OFS = 8'h04;
  localparam logic [7:0] CFG_REG_OFS = 8'h08;
  localparam logic [7:0] LP_REG_OFS = 8'h10;
  localparam logic [7:0] IEN_SET_OFS = 8'h14;
  localparam logic [7:0] IEN_CLR_OFS = 8'h18;
  localparam logic [7:0] IMASK_OFS = 8'h1C;
  localparam logic [7:0] ISTAT_OFS = 8'h20;
  localparam logic [7:0] MDEV_OFS = 8'h24;
  localparam logic [7:0] CFG1_OFS = 8'h28;
  localparam logic [7:0] SCRAM_OFS = 8'h2C;

  // ********************************************************
  // values after reset
  // ********************************************************
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic [11:0] REFR_RST = 12'h000;
  localparam logic [31:0] CFG_RST = 32'h852372C0;
  localparam logic [31:0] LP_RST = 32'h00000000;
  localparam logic [31:0] MDEV_RST = 32'h00000000;
  localparam logic [31:0] CFG1_RST = 32'h00000002;
  localparam logic [31:0] SCRAM_RST = 32'h00000000;

  // ********************************************************
  // field positions of the geometry and timing word and of the low-power mode field
  // ********************************************************
  localparam int COL_LSB = 0;
  localparam int ROW_LSB = 2;
  localparam int BANK_BIT = 4;
  localparam int CAS_LSB = 5;
  localparam int WIDTH_BIT = 7;
  localparam int TWR_LSB = 8;
  localparam int TRC_LSB = 12;
  localparam int TRP_LSB = 16;
  localparam int ACT_TO_RW_DELAY_LSB = 20;
  localparam int ACT_TO_PRE_DELAY_LSB = 24;
  localparam int SELFREF_EXIT_DELAY_LSB = 28;
  localparam int LP_MODE_LSB = 0;

  // ********************************************************
  // encodings and counts
  // ********************************************************
  typedef enum logic [2:0] {
    MODE_NORMAL = 3'b000,
    MODE_NOP = 3'b001,
    MODE_PRE_ALL = 3'b010,
    MODE_LOAD = 3'b011,
    MODE_REFRESH = 3'b100,
    MODE_EXT_LOAD = 3'b101,
    MODE_DEEP = 3'b110
  } cmd_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ACT_WAIT = 3'b001,
    ST_DATA_WAIT = 3'b010,
    ST_PRE = 3'b011,
    ST_GAP = 3'b100,
    ST_EXIT_SR = 3'b101
  } ctl_state_t;

  // {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_BST = 4'h6;

  localparam logic [1:0] LP_SELF = 2'b01;
  localparam logic [12:0] PRE_ALL_ADDR = 13'h0400;
  localparam logic [4:0] BASE_COL_BITS = 5'h08;
  localparam logic [4:0] BASE_ROW_BITS = 5'h0B;
  localparam logic [3:0] SYNC_EXTRA = 4'h3;
  localparam logic [3:0] CMD_SETTLE = 4'h1;
  localparam logic [7:0] SINCE_MAX = 8'hFF;

endpackage

// [src/sdram_ctrl_config_regs.sv]
// sdram controller: register file, command modes, refresh and timing engine
//
// Function
// - mode 000 decodes accesses as normal transfers
// - modes 001-011 issue nop, precharge-all, mode load
// - mode 100 issues auto-refresh, with no precharge first
// - mode 101 issues extended load to addressed bank
// - mode 110 puts memory in deep power-down
// - 12-bit count reloads timer, pulse starts refresh
// - count never written means no timer refresh ever
// - column field selects 8 to 11 bits
// - row field selects 11 to 13 bits
// - bank bit selects two or four banks
// - latency field selects 1 to 3 cycles
// - write recovery wait from 4-bit count
// - one count spaces refresh and activate commands
// - wait precharge delay after every precharge
// - wait row-to-column delay after activate
// - keep active-to-precharge delay before precharge
// - wait exit delay after clock enable rises
// - missed refresh flags error, status read clears
`timescale 1ns/10ps

module sdram_ctrl_config_regs
  import sdram_cfg_pkg::*;
#(
  parameter int ADDR_W = 26,
  parameter int DQ_W = 16
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // register bus
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // memory region port
  input wire logic mem_read,
  input wire logic mem_write,
  input wire logic [ADDR_W-1:0] mem_address,
  input wire logic [DQ_W-1:0] mem_writedata,
  output logic [DQ_W-1:0] mem_readdata,
  output logic mem_waitrequest,
  // sdram pins
  output logic mem_clock_enable,
  output logic sd_cs_n,
  output logic sd_ras_n,
  output logic sd_cas_n,
  output logic sd_we_n,
  output logic [1:0] sd_ba,
  output logic [12:0] sd_addr,
  output logic [DQ_W-1:0] sd_dq_out,
  output logic sd_dq_oe,
  input wire logic [DQ_W-1:0] sd_dq_in
);

  // ********************************************************
  // state
  // ********************************************************
  typedef struct packed {
    logic [2:0] mode;
    logic [11:0] refr;
    logic ref_armed;
    logic [31:0] cfg;
    logic [31:0] lp;
    logic ien;
    logic err;
    logic [31:0] mdev;
    logic [31:0] cfg1;
    logic [31:0] scram;
    logic avs_wait;
    logic [31:0] avs_rdata;
    ctl_state_t state;
    logic [3:0] cnt;
    logic [3:0] ras_cnt;
    logic [3:0] trc_cnt;
    logic [11:0] timer;
    logic ref_pend;
    logic rd_op;
    logic cke;
    logic [3:0] cmd;
    logic [1:0] ba;
    logic [12:0] a;
    logic [DQ_W-1:0] dq_out;
    logic dq_oe;
    logic mem_wait;
    logic [DQ_W-1:0] mem_rdata;
    logic [DQ_W-1:0] sync1;
    logic [DQ_W-1:0] sync2;
  } ctl_st_t;

  localparam ctl_st_t ST_RESET = '{
    mode: MODE_RST, refr: REFR_RST, ref_armed: 1'b0, cfg: CFG_RST,
    lp: LP_RST, ien: 1'b0, err: 1'b0, mdev: MDEV_RST, cfg1: CFG1_RST,
    scram: SCRAM_RST, avs_wait: 1'b1, avs_rdata: 32'h00000000,
    state: ST_IDLE, cnt: 4'h0, ras_cnt: 4'h0, trc_cnt: 4'h0,
    timer: 12'h000, ref_pend: 1'b0, rd_op: 1'b0, cke: 1'b1,
    cmd: CMD_NOP, ba: 2'h0, a: 13'h0000, dq_out: '0, dq_oe: 1'b0,
    mem_wait: 1'b1, mem_rdata: '0, sync1: '0, sync2: '0
  };

  ctl_st_t st_q;
  ctl_st_t st_d;

  function automatic logic [31:0] merge_be(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

  // ********************************************************
  // field decode and address split
  // ********************************************************
  logic [1:0] col_n;
  logic [1:0] row_n;
  logic four_banks;
  logic [1:0] cas_lat;
  logic [3:0] twr_cyc;
  logic [3:0] trc_cyc;
  logic [3:0] trp_cyc;
  logic [3:0] act_to_rw_delay_cyc;
  logic [3:0] act_to_pre_delay_cyc;
  logic [3:0] selfref_exit_delay_cyc;
  logic [4:0] col_bits;
  logic [4:0] bank_bits;
  logic [4:0] row_bits;
  logic [ADDR_W-1:0] col_all;
  logic [ADDR_W-1:0] bank_all;
  logic [ADDR_W-1:0] row_all;
  logic [12:0] row_pins;
  logic [12:0] col_pins;
  logic [1:0] bank_sel;

  // reserved row and latency codes are kept as written; they only
  // bend the address split or the wait, they never lock the engine
  always_comb begin
    col_n = st_q.cfg[COL_LSB +: 2];
    row_n = st_q.cfg[ROW_LSB +: 2];
    four_banks = st_q.cfg[BANK_BIT];
    cas_lat = st_q.cfg[CAS_LSB +: 2];
    twr_cyc = st_q.cfg[TWR_LSB +: 4];
    trc_cyc = st_q.cfg[TRC_LSB +: 4];
    trp_cyc = st_q.cfg[TRP_LSB +: 4];
    act_to_rw_delay_cyc = st_q.cfg[ACT_TO_RW_DELAY_LSB +: 4];
    act_to_pre_delay_cyc = st_q.cfg[ACT_TO_PRE_DELAY_LSB +: 4];
    selfref_exit_delay_cyc = st_q.cfg[SELFREF_EXIT_DELAY_LSB +: 4];
    col_bits = BASE_COL_BITS + {3'b000, col_n};
    bank_bits = four_banks ? 5'h02 : 5'h01;
    row_bits = BASE_ROW_BITS + {3'b000, row_n};
    col_all = mem_address & ~({ADDR_W{1'b1}} << col_bits);
    bank_all = mem_address >> col_bits;
    row_all = mem_address >> (col_bits + bank_bits);
    row_pins = row_all[12:0] & ~(13'h1FFF << row_bits);
    // a10 stays low on column commands; column bit 10 moves to a11
    col_pins = {1'b0, col_all[10], 1'b0, col_all[9:0]};
    bank_sel = four_banks ? bank_all[1:0] : {1'b0, bank_all[0]};
  end

  // ********************************************************
  // register read mux
  // ********************************************************
  logic [31:0] rd_word;

  always_comb begin
    case (avs_address)
      MODE_REG_OFS: rd_word = {29'h00000000, st_q.mode};
      REFR_REG_OFS: rd_word = {20'h00000, st_q.refr};
      CFG_REG_OFS: rd_word = st_q.cfg;
      LP_REG_OFS: rd_word = st_q.lp;
      IMASK_OFS: rd_word = {31'h00000000, st_q.ien};
      ISTAT_OFS: rd_word = {31'h00000000, st_q.err};
      MDEV_OFS: rd_word = st_q.mdev;
      CFG1_OFS: rd_word = st_q.cfg1;
      SCRAM_OFS: rd_word = st_q.scram;
      default: rd_word = 32'h00000000;
    endcase
  end

  // ********************************************************
  // next state
  // ********************************************************
  logic bus_take;
  logic bus_fire;
  logic refr_wr;
  logic ref_pulse;
  logic mem_req;
  logic [31:0] refr_word;

  always_comb begin
    st_d = st_q;
    bus_take = (avs_read || avs_write) && st_q.avs_wait;
    bus_fire = avs_write && !st_q.avs_wait;
    refr_wr = bus_fire && (avs_address == REFR_REG_OFS);
    mem_req = mem_read || mem_write;
    ref_pulse = 1'b0;
    refr_word = merge_be({20'h00000, st_q.refr}, avs_writedata,
                         avs_byteenable);

    // register bus: latch on the first edge, answer on the next
    st_d.avs_wait = 1'b1;
    if (bus_take) begin
      st_d.avs_wait = 1'b0;
      st_d.avs_rdata = rd_word;
      // clear where the value is latched so no event slips between
      if (avs_read && avs_address == ISTAT_OFS) begin
        st_d.err = 1'b0;
      end
    end
    if (bus_fire) begin
      case (avs_address)
        MODE_REG_OFS: st_d.mode = avs_byteenable[0] ?
                                  avs_writedata[2:0] : st_q.mode;
        REFR_REG_OFS: begin
          st_d.refr = refr_word[11:0];
          st_d.ref_armed = 1'b1;
        end
        CFG_REG_OFS: st_d.cfg = merge_be(st_q.cfg, avs_writedata,
                                         avs_byteenable);
        LP_REG_OFS: st_d.lp = merge_be(st_q.lp, avs_writedata,
                                       avs_byteenable);
        IEN_SET_OFS: st_d.ien = st_q.ien | avs_writedata[0];
        IEN_CLR_OFS: st_d.ien = st_q.ien & ~avs_writedata[0];
        MDEV_OFS: st_d.mdev = merge_be(st_q.mdev, avs_writedata,
                                       avs_byteenable);
        CFG1_OFS: st_d.cfg1 = merge_be(st_q.cfg1, avs_writedata,
                                       avs_byteenable);
        SCRAM_OFS: st_d.scram = merge_be(st_q.scram, avs_writedata,
                                         avs_byteenable);
        default: st_d.avs_wait = 1'b1;
      endcase
    end

    // command engine
    st_d.cmd = CMD_NOP;
    st_d.dq_oe = 1'b0;
    st_d.mem_wait = 1'b1;
    st_d.cnt = (st_q.cnt != 4'h0) ? st_q.cnt - 4'h1 : 4'h0;
    st_d.ras_cnt = (st_q.ras_cnt != 4'h0) ? st_q.ras_cnt - 4'h1 : 4'h0;
    st_d.trc_cnt = (st_q.trc_cnt != 4'h0) ? st_q.trc_cnt - 4'h1 : 4'h0;
    st_d.sync1 = sd_dq_in;
    st_d.sync2 = st_q.sync1;
    case (st_q.state)
      ST_IDLE: begin
        if (st_q.ref_pend && st_q.cke) begin
          if (st_q.trc_cnt == 4'h0) begin
            st_d.cmd = CMD_REF;
            st_d.trc_cnt = trc_cyc;
            st_d.ref_pend = 1'b0;
          end
        end else if (mem_req) begin
          st_d.ba = bank_sel;
          case (st_q.mode)
            MODE_NORMAL: begin
              if (!st_q.cke) begin
                st_d.cke = 1'b1;
                st_d.cnt = selfref_exit_delay_cyc;
                st_d.state = ST_EXIT_SR;
              end else if (st_q.trc_cnt == 4'h0) begin
                st_d.cmd = CMD_ACT;
                st_d.a = row_pins;
                st_d.trc_cnt = trc_cyc;
                st_d.ras_cnt = act_to_pre_delay_cyc;
                st_d.cnt = act_to_rw_delay_cyc;
                st_d.rd_op = mem_read;
                st_d.state = ST_ACT_WAIT;
              end
            end
            MODE_NOP: begin
              st_d.cmd = CMD_NOP;
              st_d.cnt = CMD_SETTLE;
              st_d.mem_wait = 1'b0;
              st_d.state = ST_GAP;
            end
            MODE_PRE_ALL: begin
              st_d.cmd = CMD_PRE;
              st_d.a = PRE_ALL_ADDR;
              st_d.cnt = trp_cyc;
              st_d.mem_wait = 1'b0;
              st_d.state = ST_GAP;
            end
            MODE_LOAD, MODE_EXT_LOAD: begin
              // extended load lands in the bank the address selects
              st_d.cmd = CMD_MRS;
              st_d.a = mem_address[12:0];
              st_d.cnt = CMD_SETTLE;
              st_d.mem_wait = 1'b0;
              st_d.state = ST_GAP;
            end
            MODE_REFRESH: begin
              if (st_q.trc_cnt == 4'h0) begin
                st_d.cmd = CMD_REF;
                st_d.trc_cnt = trc_cyc;
                st_d.mem_wait = 1'b0;
                st_d.state = ST_GAP;
              end
            end
            MODE_DEEP: begin
              st_d.cmd = CMD_BST;
              st_d.cke = 1'b0;
              st_d.cnt = CMD_SETTLE;
              st_d.mem_wait = 1'b0;
              st_d.state = ST_GAP;
            end
            default: begin
              st_d.mem_wait = 1'b0;
              st_d.state = ST_GAP;
            end
          endcase
        end else if (st_q.lp[LP_MODE_LSB +: 2] == LP_SELF && st_q.cke &&
                     st_q.mode == MODE_NORMAL &&
                     st_q.trc_cnt == 4'h0) begin
          st_d.cmd = CMD_REF;
          st_d.cke = 1'b0;
          st_d.trc_cnt = trc_cyc;
        end
      end
      ST_ACT_WAIT: begin
        if (st_q.cnt == 4'h0) begin
          st_d.a = col_pins;
          if (st_q.rd_op) begin
            st_d.cmd = CMD_READ;
            st_d.cnt = {2'b00, cas_lat} + SYNC_EXTRA;
          end else begin
            st_d.cmd = CMD_WRITE;
            st_d.dq_out = mem_writedata;
            st_d.dq_oe = 1'b1;
            st_d.cnt = twr_cyc;
          end
          st_d.state = ST_DATA_WAIT;
        end
      end
      ST_DATA_WAIT: begin
        if (st_q.cnt == 4'h0) begin
          if (st_q.rd_op) begin
            st_d.mem_rdata = st_q.sync2;
          end
          st_d.state = ST_PRE;
        end
      end
      ST_PRE: begin
        if (st_q.ras_cnt == 4'h0) begin
          st_d.cmd = CMD_PRE;
          st_d.a = PRE_ALL_ADDR;
          st_d.cnt = trp_cyc;
          st_d.mem_wait = 1'b0;
          st_d.state = ST_GAP;
        end
      end
      ST_GAP, ST_EXIT_SR: begin
        if (st_q.cnt == 4'h0) begin
          st_d.state = ST_IDLE;
        end
      end
      default: st_d.state = ST_IDLE;
    endcase

    // refresh interval timer; a new count restarts the period
    if (refr_wr) begin
      st_d.timer = st_d.refr;
    end else if (!st_q.ref_armed || st_q.refr == 12'h000) begin
      st_d.timer = st_q.refr;
    end else if (st_q.timer <= 12'h001) begin
      ref_pulse = 1'b1;
      st_d.timer = st_q.refr;
    end else begin
      st_d.timer = st_q.timer - 12'h001;
    end
    // a sleeping device needs no pulse; a pulse on top of a pending
    // one is a missed refresh and wins over the read clear
    if (ref_pulse && st_q.cke) begin
      if (st_q.ref_pend && st_d.ref_pend) begin
        st_d.err = 1'b1;
      end
      st_d.ref_pend = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign avs_readdata = st_q.avs_rdata;
  assign avs_waitrequest = st_q.avs_wait;
  assign mem_readdata = st_q.mem_rdata;
  assign mem_waitrequest = st_q.mem_wait;
  assign mem_clock_enable = st_q.cke;
  assign {sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n} = st_q.cmd;
  assign sd_ba = st_q.ba;
  assign sd_addr = st_q.a;
  assign sd_dq_out = st_q.dq_out;
  assign sd_dq_oe = st_q.dq_oe;

  // ********************************************************
  // checks
  // ********************************************************
  logic [7:0] since_act;
  logic [7:0] since_pre;
  logic [7:0] since_rc;
  logic [7:0] since_cke;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      since_act <= SINCE_MAX;
      since_pre <= SINCE_MAX;
      since_rc <= SINCE_MAX;
      since_cke <= SINCE_MAX;
    end else begin
      since_act <= (st_q.cmd == CMD_ACT) ? 8'h00 :
                   (since_act == SINCE_MAX) ? since_act : since_act + 8'h01;
      since_pre <= (st_q.cmd == CMD_PRE) ? 8'h00 :
                   (since_pre == SINCE_MAX) ? since_pre : since_pre + 8'h01;
      since_rc <= (st_q.cmd == CMD_ACT || st_q.cmd == CMD_REF) ? 8'h00 :
                  (since_rc == SINCE_MAX) ? since_rc : since_rc + 8'h01;
      since_cke <= !st_q.cke ? 8'h00 :
                   (since_cke == SINCE_MAX) ? since_cke : since_cke + 8'h01;
    end
  end

  rcd_spacing_a: assert property (@(posedge clock) disable iff (!rst_n)
    (st_q.cmd == CMD_READ || st_q.cmd == CMD_WRITE) |-> since_act >= act_to_rw_delay_cyc)
    else $error("read or write too soon after activate");
  pre_spacing_a: assert property (@(posedge clock) disable iff (!rst_n)
    (st_q.cmd != CMD_NOP) |-> since_pre >= trp_cyc)
    else $error("command too soon after precharge");
  ras_spacing_a: assert property (@(posedge clock) disable iff (!rst_n)
    (st_q.cmd == CMD_PRE) |-> since_act >= act_to_pre_delay_cyc)
    else $error("precharge too soon after activate");
  rc_spacing_a: assert property (@(posedge clock) disable iff (!rst_n)
    (st_q.cmd == CMD_ACT || st_q.cmd == CMD_REF) |-> since_rc >= trc_cyc)
    else $error("activate or refresh spacing too short");
  xsr_spacing_a: assert property (@(posedge clock) disable iff (!rst_n)
    (st_q.cmd == CMD_ACT) |-> st_q.cke && since_cke > selfref_exit_delay_cyc)
    else $error("activate too soon after clock enable rose");
  no_refresh_a: assert property (@(posedge clock) disable iff (!rst_n)
    !st_q.ref_armed |-> !st_q.ref_pend && st_q.timer == st_q.refr)
    else $error("refresh pending with count never written");
  act_normal_a: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(st_q.state == ST_ACT_WAIT) |-> $past(st_q.mode) == MODE_NORMAL)
    else $error("activate outside normal mode");
  deep_down_a: assert property (@(posedge clock) disable iff (!rst_n)
    (st_q.cmd == CMD_BST) |-> !st_q.cke ##1 !st_q.cke)
    else $error("deep power-down without clock enable low");
  err_set_a: assert property (@(posedge clock) disable iff (!rst_n)
    (ref_pulse && st_q.cke && st_q.ref_pend &&
     (st_q.state != ST_IDLE || st_q.trc_cnt != 4'h0))
      |=> st_q.err)
    else $error("missed refresh not flagged");
  err_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
    (bus_take && avs_read && avs_address == ISTAT_OFS && !ref_pulse)
      |=> !st_q.err && !avs_waitrequest)
    else $error("status read did not clear error");

endmodule // sdram_ctrl_config_regs

// [tb/sdram_partner_model.sv]
// behavioural sdram device on the memory pins
`timescale 1ns/10ps
module sdram_partner_model import sdram_cfg_pkg::*; (
  // clock and latency in use
  input wire logic clock,
  input wire logic [1:0] cas_lat,
  // controller pins
  input wire logic cke,
  input wire logic [3:0] cmd,
  input wire logic [12:0] addr,
  input wire logic [15:0] dq_out,
  input wire logic dq_oe,
  // read data
  output logic [15:0] dq_in
);
  // ****************
  // storage
  // ****************
  logic [15:0] mem_q [16];
  logic [15:0] rd_q;
  logic [15:0] noise_q = 16'h5A5A;
  logic [3:0] pipe_q = 4'h0;
  // toggling bus outside a burst so stale data never looks valid
  always_comb dq_in = (pipe_q[cas_lat - 2'h1] | pipe_q[cas_lat]) ?
    rd_q : noise_q;
  always @(posedge clock) begin
    noise_q <= ~noise_q;
    pipe_q <= {pipe_q[2:0], cke && cmd == CMD_READ};
    if (cke && cmd == CMD_READ)
      rd_q <= mem_q[addr[3:0]];
    if (cke && cmd == CMD_WRITE && dq_oe)
      mem_q[addr[3:0]] <= dq_out;
  end
endmodule // sdram_partner_model

// [tb/sdram_ctrl_config_regs_test.sv]
// self-checking bench of the sdram control block
`timescale 1ns/10ps
module sdram_ctrl_config_regs_test import sdram_cfg_pkg::*; ();
  // ****************
  // signals
  // ****************
  logic clock = 1'h0, rst_n = 1'h0;
  logic [7:0] avs_address = 8'h0;
  logic avs_read = 1'h0, avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, mem_waitrequest, mem_clock_enable, sd_dq_oe;
  logic mem_read = 1'h0, mem_write = 1'h0;
  logic [25:0] mem_address = 26'h0;
  logic [15:0] mem_writedata = 16'h0;
  logic [15:0] mem_readdata, sd_dq_out, sd_dq_in;
  logic sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n;
  logic [1:0] sd_ba, last_ba, act_ba;
  logic [12:0] sd_addr, act_a;
  logic [1:0] cas_l = 2'h2;
  logic [3:0] last_cmd;
  wire logic [3:0] cmd = {sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n};
  int cyc, act_c, rw_c, pre_c, ref_n, ref_at, n_cmd, err_total, checked;
  int gap_min = 1000;
  sdram_ctrl_config_regs i_dut (.clock, .rst_n, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable(4'hF), .avs_readdata,
    .avs_waitrequest, .mem_read, .mem_write, .mem_address, .mem_writedata,
    .mem_readdata, .mem_waitrequest, .mem_clock_enable, .sd_cs_n, .sd_ras_n,
    .sd_cas_n, .sd_we_n, .sd_ba, .sd_addr, .sd_dq_out, .sd_dq_oe, .sd_dq_in);
  sdram_partner_model i_mem (.clock, .cas_lat(cas_l), .cke(mem_clock_enable),
    .cmd, .addr(sd_addr), .dq_out(sd_dq_out), .dq_oe(sd_dq_oe),
    .dq_in(sd_dq_in));
  always #10 clock = ~clock;
  // pin monitor: edge numbers of the last commands
  always @(posedge clock) begin
    if (cyc == 5000) begin
      err_total++;
      end_of_test();
    end
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cmd !== CMD_NOP) begin
      n_cmd <= n_cmd + 1;
      last_cmd <= cmd;
      last_ba <= sd_ba;
    end
    if (cmd === CMD_ACT) begin
      act_c <= cyc;
      act_a <= sd_addr;
      act_ba <= sd_ba;
    end
    if (cmd === CMD_READ || cmd === CMD_WRITE) rw_c <= cyc;
    if (cmd === CMD_PRE) pre_c <= cyc;
    if (cmd === CMD_REF) begin
      ref_n <= ref_n + 1;
      ref_at <= cyc;
      if (ref_n > 0 && cyc - ref_at < gap_min) gap_min <= cyc - ref_at;
    end
  end
  task automatic check(input string what, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic reg_io(input logic wr, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clock); while (avs_waitrequest !== 1'h0);
    q = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
  endtask
  task automatic mem_io(input logic wr, input logic [25:0] a,
      input logic [15:0] d, output logic [15:0] q);
    @(posedge clock);
    mem_address <= a;
    mem_writedata <= d;
    mem_write <= wr;
    mem_read <= !wr;
    do @(posedge clock); while (mem_waitrequest !== 1'h0);
    q = mem_readdata;
    mem_write <= 1'h0;
    mem_read <= 1'h0;
    @(negedge clock);
  endtask
  task automatic t_regs;
    logic [7:0] ofs [10] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h1C,
      8'h20, 8'h24, 8'h28, 8'h30};
    logic [31:0] q;
    foreach (ofs[i]) begin
      reg_io(1'h0, ofs[i], 32'h0, q);
      check("reset", q, i == 2 ? 32'h852372C0 : i == 8 ? 32'h2 : 32'h0);
    end
    reg_io(1'h1, 8'h20, 32'hFFFFFFFF, q);
    reg_io(1'h0, 8'h20, 32'h0, q);
    check("status ro", q, 32'h0);
    reg_io(1'h1, 8'h08, 32'h4942639D, q);
    reg_io(1'h0, 8'h08, 32'h0, q);
    check("cfg kept", q, 32'h4942639D);
  endtask
  task automatic t_timing(input logic [31:0] cfg, input int act_to_rw_delay, act_to_pre_delay,
      write_recovery_cycles, cas, precharge_delay, input logic [25:0] ma, input logic [12:0] er,
      input logic [1:0] eb);
    logic [31:0] q;
    logic [15:0] d;
    int w_pre;
    reg_io(1'h1, 8'h08, cfg, q);
    cas_l <= cas[1:0];
    mem_io(1'h1, ma, 16'hA5C3, d);
    check("act row", act_a, er);
    check("act bank", act_ba, eb);
    check("act-wr", rw_c - act_c, act_to_rw_delay + 1);
    check("act-pre wr", pre_c - act_c,
      act_to_rw_delay + write_recovery_cycles + 3 > act_to_pre_delay + 1 ? act_to_rw_delay + write_recovery_cycles + 3 : act_to_pre_delay + 1);
    w_pre = pre_c;
    mem_io(1'h0, ma, 16'h0, d);
    check("rd data", d, 16'hA5C3);
    check("pre gap", act_c - w_pre >= precharge_delay + 2, 1);
    check("act-pre rd", pre_c - act_c,
      act_to_rw_delay + cas + 6 > act_to_pre_delay + 1 ? act_to_rw_delay + cas + 6 : act_to_pre_delay + 1);
  endtask
  task automatic t_modes;
    logic [3:0] exp [7] = '{CMD_NOP, CMD_NOP, CMD_PRE, CMD_MRS, CMD_REF,
      CMD_MRS, CMD_BST};
    logic [31:0] q;
    logic [15:0] d;
    int n;
    for (int m = 1; m < 7; m++) begin
      reg_io(1'h1, 8'h00, m, q);
      n = n_cmd;
      mem_io(1'h1, 26'h100, 16'h0, d);
      if (m == 1) check("nop", n_cmd - n, 0);
      else begin
        check("mode count", n_cmd - n, 1);
        check("mode cmd", last_cmd, exp[m]);
      end
      if (m == 5) check("ext bank", last_ba, 2'h1);
    end
    check("deep cke", mem_clock_enable, 1'h0);
    reg_io(1'h1, 8'h00, 32'h0, q);
    mem_io(1'h1, 26'h7, 16'h3C5A, d);
    mem_io(1'h0, 26'h7, 16'h0, d);
    check("normal", {mem_clock_enable, d}, {1'h1, 16'h3C5A});
  endtask
  task automatic t_refresh;
    logic [31:0] q;
    int r;
    r = ref_n;
    repeat (300) @(posedge clock);
    check("unarmed", ref_n - r, 0);
    reg_io(1'h1, 8'h04, 32'h28, q);
    r = ref_n;
    repeat (400) @(posedge clock);
    check("ref count", (ref_n - r) inside {[9:11]}, 1);
    reg_io(1'h1, 8'h04, 32'h1, q);
    repeat (60) @(posedge clock);
    reg_io(1'h1, 8'h04, 32'hFFF, q);
    reg_io(1'h0, 8'h20, 32'h0, q);
    check("ref error", q, 32'h1);
    reg_io(1'h0, 8'h20, 32'h0, q);
    check("err cleared", q, 32'h0);
    check("ref gap", gap_min >= 7, 1);
  endtask
  task automatic end_of_test;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clock);
    rst_n <= 1'h1;
    t_regs;
    $display("regs done");
    t_timing(32'h894263F5, 4, 9, 3, 3, 2, 26'hAD1C05, 13'h05A3, 2'h2);
    t_timing(32'h852372C0, 2, 5, 2, 2, 3, 26'h158705, 13'h02C3, 2'h1);
    $display("timing done");
    t_modes;
    $display("modes done");
    t_refresh;
    $display("refresh done");
    end_of_test();
  end
endmodule // sdram_ctrl_config_regs_test
